// >>> hdl/mem_card_pkg.sv
// Shared constants and carriers for the switch-set memory card decoder
package mem_card_pkg;

   localparam int ADDR_W      = 16;
   localparam int DATA_W      = 8;
   localparam int BLOCK_AW    = 10;                 // 1K socket block
   localparam int RAM_AW      = 12;                 // 4K RAM window
   localparam int BANK8_SHIFT = 13;                 // 8K bank boundary
   localparam int BANK4_SHIFT = 12;                 // 4K bank boundary
   localparam int SOCKETS_8K  = 8;
   localparam int SOCKETS_4K  = 4;
   localparam int SOCKETS     = SOCKETS_8K + SOCKETS_4K;
   localparam int SOCK_W      = 4;
   localparam logic [SOCK_W-1:0] SOCK_4K_FIRST = 4'h8;
   localparam logic [2:0] UPPER_TOP_SETTING = 3'h7; // bank at E000
   localparam logic [3:0] LOWER_TOP_SETTING = 4'hF; // window at F000
   localparam logic [2:0] TOP_SOCKET_8K     = 3'h7;
   localparam logic [1:0] TOP_SOCKET_4K     = 2'h3;

   typedef enum logic {
      CARD_COMBO,
      CARD_PROM_ONLY
   } card_kind_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              read_strobe;
      logic              write_strobe;
      logic [DATA_W-1:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic [2:0] upper;
      logic [3:0] lower;
   } switch_set_s;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic              drive_n;
   } bus_rsp_s;

endpackage : mem_card_pkg

// >>> hdl/card_ram.sv
// 4K by 8 static RAM with registered read data
`timescale 1ns/1ps
module card_ram
   import mem_card_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              we,
   input  wire logic [RAM_AW-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic      [DATA_W-1:0] rdata
);

   logic [DATA_W-1:0] mem [0:(1<<RAM_AW)-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[addr];
   end

endmodule : card_ram

// >>> hdl/card_prom.sv
// Twelve 1K PROM sockets, preset contents, registered read data
`timescale 1ns/1ps
module card_prom
   import mem_card_pkg::*;
#(
   parameter logic [DATA_W-1:0] FILL = 8'hFF      // Arbitrary blank fill
)
(
   input  wire logic                       clk,
   input  wire logic [SOCK_W+BLOCK_AW-1:0] addr,
   output logic      [DATA_W-1:0]          rdata
);

   logic [DATA_W-1:0] mem [0:SOCKETS*(1<<BLOCK_AW)-1];

   // Contents stand in for programmed parts; read only
   initial begin
      for (int i = 0; i < SOCKETS*(1<<BLOCK_AW); i++) begin
         mem[i] = FILL ^ DATA_W'(i);
      end
   end

   always_ff @(posedge clk) begin
      rdata <= mem[addr];
   end

endmodule : card_prom

// >>> hdl/switch_set_memory_decoder.sv
// Address decoder and chip select for plug-in memory expansion cards
`timescale 1ns/1ps
module switch_set_memory_decoder
   import mem_card_pkg::*;
#(
   parameter card_kind_e CARD_KIND = CARD_COMBO
)
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [ADDR_W-1:0]     addr,
   input  wire logic                  memory_read_strobe,
   input  wire logic                  memory_write_strobe,
   input  wire logic [DATA_W-1:0]     data_in,
   input  wire logic [2:0]            upper_switch,
   input  wire logic [3:0]            lower_switch,
   input  wire logic [SOCKETS-1:0]    socket_fitted,
   output logic      [DATA_W-1:0]     data_out,
   output logic                       data_oe_n,
   output logic                       wait_cycle_request,
   output logic                       setting_conflict
);

   // Switches and strobes arrive from the cable, asynchronous to clk
   logic [2:0]        up_s1, up_s2, up_s3;
   logic [3:0]        lo_s1, lo_s2, lo_s3;
   logic [2:0]        rd_sync, wr_sync;
   switch_set_s       sw;
   bus_req_s          req;
   logic              rd_now, wr_now;
   logic [ADDR_W-1:0] addr_s1, addr_s2, addr_s3;
   logic [DATA_W-1:0] wd_s1, wd_s2, wd_s3;

   // Address and data ride the same three stages as the strobes, so a write
   // still sees its own data after the bus has let go of the lines
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_s1 <= '0;
         addr_s2 <= '0;
         addr_s3 <= '0;
         wd_s1   <= '0;
         wd_s2   <= '0;
         wd_s3   <= '0;
      end else begin
         addr_s1 <= addr;
         addr_s2 <= addr_s1;
         addr_s3 <= addr_s2;
         wd_s1   <= data_in;
         wd_s2   <= wd_s1;
         wd_s3   <= wd_s2;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         up_s1 <= '0;
         up_s2 <= '0;
         up_s3 <= '0;
         lo_s1 <= '0;
         lo_s2 <= '0;
         lo_s3 <= '0;
      end else begin
         up_s1 <= upper_switch;
         up_s2 <= up_s1;
         up_s3 <= up_s2;
         lo_s1 <= lower_switch;
         lo_s2 <= lo_s1;
         lo_s3 <= lo_s2;
      end
   end

   // Base only moves once two later stages agree; filters bounce while turning
   always_ff @(posedge clk) begin
      if (rst) begin
         sw <= '0;
      end else begin
         if (up_s2 == up_s3) begin
            sw.upper <= up_s3;
         end
         if (lo_s2 == lo_s3) begin
            sw.lower <= lo_s3;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_sync <= '0;
         wr_sync <= '0;
      end else begin
         rd_sync <= {rd_sync[1:0], memory_read_strobe};
         wr_sync <= {wr_sync[1:0], memory_write_strobe};
      end
   end

   // Delayed address and data line up with the filtered strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         req <= '0;
      end else begin
         req.addr         <= addr_s3;
         req.wdata        <= wd_s3;
         req.read_strobe  <= (rd_sync[1] == rd_sync[2]) ? rd_sync[2] : req.read_strobe;
         req.write_strobe <= (wr_sync[1] == wr_sync[2]) ? wr_sync[2] : req.write_strobe;
      end
   end

   assign rd_now = req.read_strobe;
   assign wr_now = req.write_strobe;

   // Window hit: compare the address bits above the window size with the base
   function automatic logic in_8k_bank(input logic [ADDR_W-1:0] a, input logic [2:0] n);
      in_8k_bank = (a[ADDR_W-1:BANK8_SHIFT] == n);
   endfunction : in_8k_bank

   function automatic logic in_4k_bank(input logic [ADDR_W-1:0] a, input logic [3:0] n);
      in_4k_bank = (a[ADDR_W-1:BANK4_SHIFT] == n);
   endfunction : in_4k_bank

   logic              hit_8k, hit_4k;
   logic [SOCK_W-1:0] socket;
   logic              socket_ok;
   logic              prom_sel, ram_sel;
   logic [SOCK_W+BLOCK_AW-1:0] prom_addr;

   always_comb begin
      hit_8k = in_8k_bank(req.addr, sw.upper);
      hit_4k = in_4k_bank(req.addr, sw.lower);
      socket = '0;
      prom_sel = 1'b0;
      ram_sel  = 1'b0;
      unique case (CARD_KIND)
         CARD_COMBO: begin
            // Socket index from 1K field; socket 0 at bank base
            socket   = {1'b0, req.addr[BANK8_SHIFT-1:BLOCK_AW]};
            prom_sel = hit_8k;
            ram_sel  = hit_4k;
         end
         CARD_PROM_ONLY: begin
            if (hit_8k) begin
               socket   = {1'b0, req.addr[BANK8_SHIFT-1:BLOCK_AW]};
               prom_sel = 1'b1;
            end else if (hit_4k) begin
               socket   = SOCK_4K_FIRST | {2'b00, req.addr[BANK4_SHIFT-1:BLOCK_AW]};
               prom_sel = 1'b1;
            end
         end
      endcase
      // Empty socket leaves the bus alone
      socket_ok = socket_fitted[socket];
      prom_addr = {socket, req.addr[BLOCK_AW-1:0]};
   end

   // Overlap between RAM and PROM windows on the combo card: RAM wins
   // so writes and reads see the same store
   logic ram_we;
   logic read_hit;

   assign ram_we   = (CARD_KIND == CARD_COMBO) && ram_sel && wr_now;
   assign read_hit = rd_now && (ram_sel || (prom_sel && socket_ok));

   logic [DATA_W-1:0] ram_rdata, prom_rdata;

   card_ram u_ram (
      .clk   (clk),
      .we    (ram_we),
      .addr  (req.addr[RAM_AW-1:0]),
      .wdata (req.wdata),
      .rdata (ram_rdata)
   );

   card_prom u_prom (
      .clk   (clk),
      .addr  (prom_addr),
      .rdata (prom_rdata)
   );

   // Memory data lands one cycle after the decode; selects are delayed to match
   logic ram_pick, read_hit_d;

   always_ff @(posedge clk) begin
      if (rst) begin
         ram_pick   <= 1'b0;
         read_hit_d <= 1'b0;
      end else begin
         ram_pick   <= ram_sel;
         read_hit_d <= read_hit;
      end
   end

   bus_rsp_s rsp;

   always_ff @(posedge clk) begin
      if (rst) begin
         rsp.rdata   <= '0;
         rsp.drive_n <= 1'b1;
      end else begin
         rsp.rdata   <= ram_pick ? ram_rdata : prom_rdata;
         rsp.drive_n <= ~(read_hit_d && read_hit);
      end
   end

   assign data_out  = rsp.rdata;
   assign data_oe_n = rsp.drive_n;

   // Fast parts: the card never stretches a cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_cycle_request <= 1'b0;
      end else begin
         wait_cycle_request <= 1'b0;
      end
   end

   // Flags switch settings that land on the processor's register region
   always_ff @(posedge clk) begin
      if (rst) begin
         setting_conflict <= 1'b0;
      end else begin
         setting_conflict <=
            (sw.upper == UPPER_TOP_SETTING &&
               socket_fitted[{1'b0, TOP_SOCKET_8K}]) ||
            (CARD_KIND == CARD_COMBO && sw.lower == LOWER_TOP_SETTING) ||
            (CARD_KIND == CARD_PROM_ONLY && sw.lower == LOWER_TOP_SETTING &&
               socket_fitted[SOCK_4K_FIRST | {2'b00, TOP_SOCKET_4K}]);
      end
   end

endmodule : switch_set_memory_decoder

// >>> tb/switch_set_memory_decoder_assertions.sv
// Port checker for the memory card decoder
`timescale 1ns/1ps
module switch_set_memory_decoder_chk
   import mem_card_pkg::*;
#(
   parameter card_kind_e CARD_KIND = CARD_COMBO
)
(
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               memory_read_strobe,
   input wire logic [2:0]         upper_switch,
   input wire logic [3:0]         lower_switch,
   input wire logic [SOCKETS-1:0] socket_fitted,
   input wire logic               data_oe_n,
   input wire logic               wait_cycle_request,
   input wire logic               setting_conflict
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence read_quiet;
      !memory_read_strobe [*6];
   endsequence
   sequence read_start;
      read_quiet ##1 memory_read_strobe;
   endsequence
   chk_no_wait: assert property (wait_cycle_request == 1'b0)
      else $error("wait request raised");
   chk_idle_release: assert property (read_quiet |-> data_oe_n)
      else $error("data driven with no read");
   chk_no_early: assert property (read_start |-> data_oe_n [*5])
      else $error("data driven before sync delay");
   chk_drive_cause: assert property ($fell(data_oe_n) |-> $past(memory_read_strobe, 4))
      else $error("drive without read strobe");
   chk_ram_conflict: assert property ((CARD_KIND == CARD_COMBO && lower_switch == 4'hF) [*8] |-> setting_conflict)
      else $error("window F not flagged");
   chk_top_conflict: assert property ((upper_switch == 3'h7 && socket_fitted[7]) [*8] |-> setting_conflict)
      else $error("top socket clash not flagged");
   chk_conflict_clear: assert property ((upper_switch != 3'h7 && lower_switch != 4'hF) [*8] |-> !setting_conflict)
      else $error("clash flagged with safe settings");
   chk_reset_quiet: assert property (@(posedge clk) disable iff (1'b0) rst |=> data_oe_n && !setting_conflict)
      else $error("outputs active after reset");
endmodule : switch_set_memory_decoder_chk

bind switch_set_memory_decoder switch_set_memory_decoder_chk #(.CARD_KIND(CARD_KIND)) i_chk (
   .clk(clk), .rst(rst), .memory_read_strobe(memory_read_strobe), .upper_switch(upper_switch),
   .lower_switch(lower_switch), .socket_fitted(socket_fitted), .data_oe_n(data_oe_n),
   .wait_cycle_request(wait_cycle_request), .setting_conflict(setting_conflict));

// >>> tb/bus_cpu_model.sv
// Processor side of the bus: one timed memory cycle per start
`timescale 1ns/1ps
module bus_cpu_model
   import mem_card_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              start,
   input  wire bus_req_s          req,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe_n,
   output bus_req_s               bus = '0,
   output logic [DATA_W-1:0]      rdata = '0,
   output logic                   roe_n = 1'b1,
   output logic                   done = 1'b0
);
   bus_req_s   cur;
   logic [4:0] cnt = '0;
   // Strobe spans 12 fast clocks, like a slow bus cycle
   always @(posedge clk) begin
      done <= 1'b0;
      if (start) begin
         cur <= req;
         cnt <= 5'h1;
      end else if (cnt != 5'h0) begin
         cnt <= cnt + 5'h1;
      end
      if (cnt == 5'h4) bus <= cur;
      if (cnt == 5'h10) begin
         rdata <= data_out;
         roe_n <= data_oe_n;
         bus.read_strobe <= 1'b0;
         bus.write_strobe <= 1'b0;
         // Released data lines must not look valid
         bus.wdata <= ~bus.wdata;
      end
      if (cnt == 5'h14) begin
         cnt <= 5'h0;
         done <= 1'b1;
      end
   end
endmodule : bus_cpu_model

// >>> tb/switch_set_memory_decoder_tb.sv
// Self-checking bench for the combination card decoder
`timescale 1ns/1ps
module switch_set_memory_decoder_tb;
   import mem_card_pkg::*;
   typedef struct packed {logic oe_n; logic chk; logic [DATA_W-1:0] data;} exp_s;
   logic              clk = 1'b0, rst = 1'b1, start = 1'b0, done, roe_n, wait_req, conflict, oe_n;
   logic [2:0]        upper_sw = '0;
   logic [3:0]        lower_sw = '0;
   logic [SOCKETS-1:0] fitted = '0;
   logic [DATA_W-1:0] dout, rdata, d;
   bus_req_s          req = '0, bus;
   int                fail_count = 0, num_checks = 0, seed = 32'h8DC71431, a;
   exp_s              exp_q[$];

   always #2 clk = ~clk;
   bus_cpu_model i_cpu (.clk(clk), .start(start), .req(req), .data_out(dout), .data_oe_n(oe_n),
      .bus(bus), .rdata(rdata), .roe_n(roe_n), .done(done));
   switch_set_memory_decoder #(.CARD_KIND(CARD_COMBO)) i_dut (.clk(clk), .rst(rst), .addr(bus.addr),
      .memory_read_strobe(bus.read_strobe), .memory_write_strobe(bus.write_strobe), .data_in(bus.wdata),
      .upper_switch(upper_sw), .lower_switch(lower_sw), .socket_fitted(fitted), .data_out(dout),
      .data_oe_n(oe_n), .wait_cycle_request(wait_req), .setting_conflict(conflict));

   task results;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   task check_bus(exp_s e);
      num_checks++;
      if (roe_n !== e.oe_n || (e.chk && rdata !== e.data)) begin
         fail_count++;
         $display("BAD bus exp %b/%h got %b/%h", e.oe_n, e.data, roe_n, rdata);
      end
   endtask : check_bus

   task check_flag(logic e);
      num_checks++;
      if (conflict !== e) begin
         fail_count++;
         $display("BAD conflict exp %b got %b", e, conflict);
      end
   endtask : check_flag

   task access(int adr, logic r, logic [DATA_W-1:0] wd, exp_s e);
      int n;
      req <= '{addr: 16'(adr), read_strobe: r, write_strobe: !r, wdata: wd};
      start <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      while (!done && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (!done) begin
         fail_count++;
         results();
      end
      @(posedge clk);
   endtask : access

   always @(posedge clk) if (done && exp_q.size() > 0) check_bus(exp_q.pop_front());

   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      fitted <= 12'h07F;
      for (int u = 0; u < 8; u++) begin
         upper_sw <= 3'(u);
         lower_sw <= (u < 4) ? 4'hE : 4'h0;
         repeat (8) @(posedge clk);
         // Offset kept below FF00 region
         a = u * 32'h2000 + u * 32'h400 + ($random(seed) & 32'hFF);
         // Preset PROM bytes are the blank fill xor the byte index
         access(a, 1'b1, 8'h00, '{u == 7, u != 7, 8'hFF ^ 8'(a)});
      end
      for (int l = 0; l < 15; l++) begin
         upper_sw <= (l < 8) ? 3'h6 : 3'h0;
         lower_sw <= 4'(l);
         repeat (8) @(posedge clk);
         d = 8'($random(seed));
         a = l * 32'h1000 + ((l % 2) ? 32'hFFF : ($random(seed) & 32'hFFF));
         access(a, 1'b0, d, '{1'b1, 1'b0, 8'h00});
         access(a, 1'b1, 8'h00, '{1'b0, 1'b1, d});
         if (l > 0) access(l * 32'h1000 - 1, 1'b1, 8'h00, '{1'b1, 1'b0, 8'h00});
      end
      upper_sw <= 3'h0;
      lower_sw <= 4'hF;
      repeat (10) @(posedge clk);
      check_flag(1'b1);
      lower_sw <= 4'h0;
      upper_sw <= 3'h7;
      fitted <= 12'h0FF;
      repeat (10) @(posedge clk);
      check_flag(1'b1);
      fitted <= 12'h07F;
      repeat (10) @(posedge clk);
      check_flag(1'b0);
      results();
   end
endmodule : switch_set_memory_decoder_tb
